// ==== hdl/fpe_regs.vh ====
// command codes, sizes and timing counts of the program/erase sequencer
`ifndef FPE_REGS_VH
`define FPE_REGS_VH
`define FPE_OP_QUAD_PAGE    8'h32
`define FPE_OP_SECTOR       8'h20
`define FPE_OP_BLK32        8'h52
`define FPE_OP_BLK64        8'hd8
`define FPE_OP_CHIP_A       8'h60
`define FPE_OP_CHIP_B       8'hc7
`define FPE_OP_SLEEP        8'hb9
`define FPE_OP_WAKE         8'hab
`define FPE_OP_RST_EN       8'h66
`define FPE_OP_RST          8'h99
`define FPE_OP_SET_WL       8'h06
`define FPE_PAGE_BYTES      256
`define FPE_CLK_NS          40
`define FPE_PP_NS           600000
`define FPE_SE_NS           50000000
`define FPE_CE_NS           100000000
`define FPE_DP_NS           3000
`define FPE_RES_NS          20000
`define FPE_PP_CYC          (`FPE_PP_NS / `FPE_CLK_NS)
`define FPE_SE_CYC          (`FPE_SE_NS / `FPE_CLK_NS)
`define FPE_CE_CYC          (`FPE_CE_NS / `FPE_CLK_NS)
`define FPE_DP_CYC          ((`FPE_DP_NS + `FPE_CLK_NS - 1) / `FPE_CLK_NS)
`define FPE_RES_CYC         ((`FPE_RES_NS + `FPE_CLK_NS - 1) / `FPE_CLK_NS)
`endif

// ==== hdl/fpe_page_mem.v ====
// page buffer: one page of bytes, registered read
`timescale 1ns/10ps
module fpe_page_mem #(
	parameter AW = 8,
	parameter DW = 8
) (
	// clock
	input  wire          clk_i,
	// write port
	input  wire          we_i,
	input  wire [AW-1:0] waddr_i,
	input  wire [DW-1:0] wdata_i,
	// read port
	input  wire [AW-1:0] raddr_i,
	output reg  [DW-1:0] rdata_o
);
	reg [DW-1:0] mem_r [0:(1<<AW)-1];

	// write and registered read
	always @(posedge clk_i) begin
		if (we_i) begin
			mem_r[waddr_i] <= wdata_i;
		end
		rdata_o <= mem_r[raddr_i];
	end
endmodule

// ==== hdl/fpe_sequencer.v ====
// program/erase/power-down command sequencer of a quad serial flash
// Behaviour
// R01: quad page write 32h: opcode, three address bytes, data on four lines, needs latch
// R02: over 256 data bytes: keep only final 256, same page
// R03: under 256 bytes: program those, other page bytes untouched
// R04: select must rise right after a whole data byte, else abandon
// R05: select rise starts timed program; busy flag one throughout, zero after
// R06: write latch flag cleared before each program or erase cycle ends
// R07: no program into a locked page
// R08: sector clear 20h with three address bytes, needs latch, any address in sector
// R09: host keeps select low from opcode through final byte
// R10: erase executes only if select rises right after third address byte
// R11: select rise starts timed erase; busy flag one until done
// R12: no sector clear of a locked sector
// R13: 32KB block clear 52h, three address bytes, needs latch
// R14: 64KB block clear d8h, three address bytes, needs latch
// R15: no block clear of a locked block
// R16: full clear 60h or c7h, no address, needs latch, select rise after opcode
// R17: full clear ignored when any sector locked
// R18: full clear runs when lock bits 2..0 set and complement bit set
// R19: sleep entry b9h; sleep begins after entry delay following select rise
// R20: in sleep only wake or reset pair accepted; they end sleep
// R21: sleep entry rejected during running cycle; cycle unaffected
// R22: select rise idle means standby; power-up starts in standby
// R23: wake abh; commands refused for release time afterwards
// R24: program or erase with latch clear silently discarded
`timescale 1ns/10ps
`include "fpe_regs.vh"
module fpe_sequencer #(
	parameter PP_CYC  = `FPE_PP_CYC,
	parameter SE_CYC  = `FPE_SE_CYC,
	parameter BE_CYC  = `FPE_SE_CYC,
	parameter CE_CYC  = `FPE_CE_CYC,
	parameter DP_CYC  = `FPE_DP_CYC,
	parameter RES_CYC = `FPE_RES_CYC
) (
	// clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// serial link pins
	input  wire        cs_n_i,
	input  wire        sclk_i,
	input  wire        io_line0_i,
	input  wire        io_line1_i,
	input  wire        io_line2_i,
	input  wire        io_line3_i,
	// protection configuration
	input  wire        region_lock_bit4_i,
	input  wire        region_lock_bit3_i,
	input  wire        region_lock_bit2_i,
	input  wire        region_lock_bit1_i,
	input  wire        region_lock_bit0_i,
	input  wire        protect_complement_bit_i,
	// status
	output reg         write_latch_flag_o,
	output reg         op_in_progress_flag_o,
	output reg         sleep_o,
	// array write strobes
	output reg         prog_we_o,
	output reg  [23:0] prog_addr_o,
	output reg  [7:0]  prog_data_o,
	output reg         erase_o,
	output reg  [1:0]  erase_kind_o,
	output reg  [23:0] erase_addr_o
);
	// states, one-hot
	localparam S_IDLE  = 5'b00001;
	localparam S_PROG  = 5'b00010;
	localparam S_ERASE = 5'b00100;
	localparam S_DPENT = 5'b01000;
	localparam S_WAKE  = 5'b10000;

	// erase kinds
	localparam EK_SECT = 2'd0;
	localparam EK_B32  = 2'd1;
	localparam EK_B64  = 2'd2;
	localparam EK_CHIP = 2'd3;

	reg [4:0]  state_r;
	reg [31:0] tmr_r;
	reg [2:0]  cs_s_r, ck_s_r;
	reg [3:0]  io_a_r, io_b_r;
	reg        quad_r;
	reg [11:0] bits_r;
	reg [7:0]  shift_r;
	reg [7:0]  op_r;
	reg [23:0] addr_r;
	reg [8:0]  ndata_r;
	reg [7:0]  wptr_r;
	reg [255:0] mark_r;
	reg        rst_en_r;
	reg [8:0]  cpy_r;
	reg        copying_r;
	wire [7:0] rd_data;

	wire cs_low  = ~cs_s_r[1];
	wire cs_rise = cs_s_r[1] & ~cs_s_r[2];
	wire ck_rise = ck_s_r[1] & ~ck_s_r[2];
	wire [4:0] lock = {region_lock_bit4_i, region_lock_bit3_i, region_lock_bit2_i,
		region_lock_bit1_i, region_lock_bit0_i};
	// buffer write on each completed data byte of a latched quad page write
	wire buf_we = state_r == S_IDLE && cs_low && ck_rise && quad_r && bits_r >= 12'd15
		&& bits_r[0] == 1'b1 && write_latch_flag_o; // R01

	// locked test: lock bits pick the top 2^(n) 64KB blocks or 4KB sectors, or with bit4 all but those
	function locked;
		input [23:0] a;
		input [4:0]  bp;
		input        cmp;
		reg   [2:0]  n;
		reg          hit;
		begin
			n = bp[2:0];
			if (n == 3'd0) begin
				hit = 1'b0;
			end else if (n == 3'd7) begin
				hit = 1'b1;
			end else begin
				// partial region: 64KB blocks, or 4KB sectors when bit3 is set
				if (bp[3]) begin
					hit = (a[23:12] >= (12'h000 - (12'h001 << n)));
				end else begin
					hit = (a[23:16] >= (8'h00 - (8'h01 << n)));
				end
				// bit4 locks everything outside the top partial region instead
				if (bp[4]) begin
					hit = ~hit;
				end
			end
			locked = cmp ? ~hit : hit;
		end
	endfunction

	// any region locked at all
	function any_locked;
		input [4:0] bp;
		input       cmp;
		begin
			any_locked = ~(cmp & (bp[2:0] == 3'b111)) & ~(~cmp & (bp[2:0] == 3'b000));
		end
	endfunction

	fpe_page_mem #(.AW(8), .DW(8)) u_page (
		.clk_i   (clk_i),
		.we_i    (buf_we),
		.waddr_i (wptr_r),
		.wdata_i ({shift_r[3:0], io_b_r}),
		.raddr_i (cpy_r[7:0]),
		.rdata_o (rd_data)
	);

	// two-flop synchronisers plus one edge stage
	always @(posedge clk_i) begin
		if (rst_i) begin
			cs_s_r <= 3'b111;
			ck_s_r <= 3'b000;
			io_a_r <= 4'h0;
			io_b_r <= 4'h0;
		end else begin
			cs_s_r <= {cs_s_r[1:0], cs_n_i};
			ck_s_r <= {ck_s_r[1:0], sclk_i};
			io_a_r <= {io_line3_i, io_line2_i, io_line1_i, io_line0_i};
			io_b_r <= io_a_r;
		end
	end

	// command shifter: opcode single line, address and data quad for quad page
	always @(posedge clk_i) begin
		if (rst_i) begin
			bits_r  <= 12'd0;
			shift_r <= 8'h00;
			op_r    <= 8'h00;
			addr_r  <= 24'h000000;
			ndata_r <= 9'd0;
			wptr_r  <= 8'h00;
			mark_r  <= 256'd0;
			quad_r  <= 1'b0;
		end else if (!cs_low) begin
			bits_r <= 12'd0;
			quad_r <= 1'b0;
		end else if (ck_rise) begin
			if (bits_r != 12'hfff) begin
				bits_r <= bits_r + 12'd1;
			end
			if (!quad_r) begin
				shift_r <= {shift_r[6:0], io_b_r[0]};
				if (bits_r == 12'd7) begin
					op_r    <= {shift_r[6:0], io_b_r[0]};
					quad_r  <= ({shift_r[6:0], io_b_r[0]} == `FPE_OP_QUAD_PAGE); // R01
					ndata_r <= 9'd0;
					mark_r  <= 256'd0;
				end else if (bits_r >= 12'd8 && bits_r <= 12'd31 && bits_r[2:0] == 3'd7) begin
					addr_r <= {addr_r[15:0], shift_r[6:0], io_b_r[0]};
				end
			end else begin
				shift_r <= {shift_r[3:0], io_b_r};
				if (bits_r >= 12'd8 && bits_r <= 12'd13 && bits_r[0] == 1'b1) begin
					// address bytes as nibble pairs, high nibble first
					addr_r <= {addr_r[15:0], shift_r[3:0], io_b_r};
					if (bits_r == 12'd13) begin
						// low address byte seeds the buffer pointer
						wptr_r <= {shift_r[3:0], io_b_r};
					end
				end else if (bits_r >= 12'd15 && bits_r[0] == 1'b1) begin
					// page wraps; later bytes overwrite earlier ones
					wptr_r  <= wptr_r + 8'd1; // R02
					mark_r[wptr_r] <= 1'b1; // R03
					if (ndata_r != 9'd256) begin
						ndata_r <= ndata_r + 9'd1;
					end
				end
			end
		end
	end

	// self-timed cycles, latch flag, sleep control
	always @(posedge clk_i) begin
		if (rst_i) begin
			state_r               <= S_IDLE; // R22
			tmr_r                 <= 32'd0;
			write_latch_flag_o    <= 1'b0;
			op_in_progress_flag_o <= 1'b0;
			sleep_o               <= 1'b0;
			rst_en_r              <= 1'b0;
			erase_o               <= 1'b0;
			erase_kind_o          <= EK_SECT;
			erase_addr_o          <= 24'h000000;
			copying_r             <= 1'b0;
			cpy_r                 <= 9'd0;
		end else begin
			// erase strobe lasts one cycle
			erase_o <= 1'b0;
			case (state_r)
			S_IDLE: begin
				if (cs_rise && sleep_o) begin
					// only wake or reset pair are heard in sleep
					if (bits_r == 12'd8 && op_r == `FPE_OP_WAKE) begin // R20
						state_r <= S_WAKE; // R23
						tmr_r   <= RES_CYC;
					end else if (bits_r == 12'd8 && op_r == `FPE_OP_RST_EN) begin
						rst_en_r <= 1'b1;
					end else if (bits_r == 12'd8 && op_r == `FPE_OP_RST && rst_en_r) begin
						sleep_o            <= 1'b0; // R20
						rst_en_r           <= 1'b0;
						write_latch_flag_o <= 1'b0;
					end else begin
						rst_en_r <= 1'b0;
					end
				end else if (cs_rise) begin
					// reset-enable arms only the next frame
					rst_en_r <= (bits_r == 12'd8 && op_r == `FPE_OP_RST_EN);
					if (bits_r == 12'd8 && op_r == `FPE_OP_SET_WL) begin
						write_latch_flag_o <= 1'b1;
					end else if (bits_r == 12'd8 && op_r == `FPE_OP_SLEEP) begin
						state_r <= S_DPENT; // R19
						tmr_r   <= DP_CYC;
					end else if (!write_latch_flag_o) begin
						state_r <= S_IDLE; // R24
					end else if (op_r == `FPE_OP_QUAD_PAGE && bits_r >= 12'd16 && bits_r[0] == 1'b0
						&& ndata_r != 9'd0) begin // R04
						if (!locked(addr_r, lock, protect_complement_bit_i)) begin // R07
							state_r               <= S_PROG; // R05
							op_in_progress_flag_o <= 1'b1;
							tmr_r                 <= PP_CYC;
							copying_r             <= 1'b1;
							cpy_r                 <= 9'd0;
						end
					end else if (bits_r == 12'd32 && (op_r == `FPE_OP_SECTOR || op_r == `FPE_OP_BLK32
						|| op_r == `FPE_OP_BLK64)) begin // R08 R10 R13 R14
						if (!locked(addr_r, lock, protect_complement_bit_i)) begin // R12 R15
							state_r               <= S_ERASE; // R11
							op_in_progress_flag_o <= 1'b1;
							erase_kind_o          <= (op_r == `FPE_OP_SECTOR) ? EK_SECT :
								(op_r == `FPE_OP_BLK32) ? EK_B32 : EK_B64;
							erase_addr_o          <= addr_r;
							tmr_r                 <= (op_r == `FPE_OP_SECTOR) ? SE_CYC : BE_CYC;
						end
					end else if (bits_r == 12'd8 && (op_r == `FPE_OP_CHIP_A || op_r == `FPE_OP_CHIP_B)) begin // R16
						if (!any_locked(lock, protect_complement_bit_i)) begin // R17 R18
							state_r               <= S_ERASE; // R11
							op_in_progress_flag_o <= 1'b1;
							erase_kind_o          <= EK_CHIP;
							erase_addr_o          <= 24'h000000;
							tmr_r                 <= CE_CYC;
						end
					end
				end
			end
			S_PROG, S_ERASE: begin
				// sleep entry arriving now is simply not decoded
				if (tmr_r == 32'd1) begin // R21
					state_r               <= S_IDLE;
					op_in_progress_flag_o <= 1'b0; // R05 R11
					write_latch_flag_o    <= 1'b0; // R06
					erase_o               <= (state_r == S_ERASE);
				end else begin
					tmr_r <= tmr_r - 32'd1;
				end
				// buffer copy to the array runs alongside the timer
				if (copying_r) begin
					cpy_r <= cpy_r + 9'd1;
					if (cpy_r == 9'd256) begin
						copying_r <= 1'b0;
					end
				end
			end
			S_DPENT: begin
				if (tmr_r == 32'd1) begin
					state_r <= S_IDLE;
					sleep_o <= 1'b1; // R19
				end else begin
					tmr_r <= tmr_r - 32'd1;
				end
			end
			S_WAKE: begin
				sleep_o <= 1'b0;
				if (tmr_r == 32'd1) begin
					state_r <= S_IDLE; // R23
				end else begin
					tmr_r <= tmr_r - 32'd1;
				end
			end
			default: begin
				state_r <= S_IDLE;
			end
			endcase
		end
	end

	// program strobes: only marked bytes are written to the array
	always @(posedge clk_i) begin
		if (rst_i) begin
			prog_we_o   <= 1'b0;
			prog_addr_o <= 24'h000000;
			prog_data_o <= 8'h00;
		end else begin
			// buffer read data lag the copy pointer by one cycle
			prog_we_o   <= copying_r && cpy_r != 9'd0 && mark_r[cpy_r[7:0] - 8'd1]; // R03
			prog_addr_o <= {addr_r[23:8], cpy_r[7:0] - 8'd1};
			prog_data_o <= rd_data;
		end
	end
endmodule

// ==== verification/fpe_sequencer_assertions.sv ====
// concurrent checks on the ports of the program/erase sequencer
`timescale 1ns/10ps
module fpe_seq_chk (
	// clock and reset
	input wire       clk_i,
	input wire       rst_i,
	// select and protection
	input wire       cs_n_i,
	input wire       region_lock_bit2_i,
	input wire       region_lock_bit1_i,
	input wire       region_lock_bit0_i,
	input wire       protect_complement_bit_i,
	// status and strobes
	input wire       write_latch_flag_o,
	input wire       op_in_progress_flag_o,
	input wire       sleep_o,
	input wire       prog_we_o,
	input wire       erase_o,
	input wire [1:0] erase_kind_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_busy_needs_latch: assert property ($rose(op_in_progress_flag_o) |-> $past(write_latch_flag_o))
		else $error("cycle started with latch clear");
	a_busy_after_cs: assert property ($rose(op_in_progress_flag_o) |-> cs_n_i && $past(cs_n_i, 2))
		else $error("cycle started with select low");
	a_busy_holds: assert property ($rose(op_in_progress_flag_o) |=> op_in_progress_flag_o [*8])
		else $error("busy flag dropped early");
	a_latch_end: assert property ($fell(op_in_progress_flag_o) |-> !write_latch_flag_o)
		else $error("latch still set after cycle");
	a_write_in_busy: assert property (prog_we_o |-> op_in_progress_flag_o)
		else $error("byte write outside cycle");
	a_erase_ends: assert property (erase_o |-> ##[0:3] !op_in_progress_flag_o)
		else $error("busy kept after erase");
	a_sleep_quiet: assert property (sleep_o |-> !op_in_progress_flag_o && !prog_we_o && !erase_o)
		else $error("activity in sleep");
	a_sleep_delay: assert property ($rose(sleep_o) |-> $past(cs_n_i, 8))
		else $error("sleep entered too early");
	a_chip_lock: assert property (erase_o && erase_kind_o == 2'h3 |-> !({region_lock_bit2_i, region_lock_bit1_i,
		region_lock_bit0_i} == 3'h7 && !protect_complement_bit_i))
		else $error("full clear with all locked");
	a_latch_set: assert property ($rose(write_latch_flag_o) |-> cs_n_i && !sleep_o)
		else $error("latch set in sleep or frame");
	c_sleep: cover property ($rose(sleep_o));
	c_chip: cover property (erase_o && erase_kind_o == 2'h3);
	c_done: cover property ($fell(op_in_progress_flag_o));
endmodule
bind fpe_sequencer fpe_seq_chk u_fpe_seq_chk (.*);

// ==== verification/fpe_host.sv ====
// host-side serial flash controller model
`timescale 1ns/10ps
module fpe_host (
	// clock
	input  wire       clk_i,
	// link pins
	output reg        cs_n_o,
	output reg        sclk_o,
	output reg  [3:0] io_o
);
	// idle link: deselected, clock still
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		io_o   = 4'h5;
	end
	// half a link period, four clocks
	task half;
		repeat (4) @(posedge clk_i);
	endtask
	// one bit or nibble, sampled at the link rising edge
	task shift(input [3:0] v);
		begin
			io_o <= v;
			half;
			sclk_o <= 1'b1;
			half;
			sclk_o <= 1'b0;
		end
	endtask
	// opcode, ns single-line address bits, then nn nibbles
	task frame(input [7:0] op, input [4:0] ns, input [23:0] sa, input [5:0] nn, input [63:0] nb);
		integer i;
		begin
			@(posedge clk_i);
			cs_n_o <= 1'b0;
			for (i = 7; i >= 0; i = i - 1) shift({3'h0, op[i]});
			for (i = 0; i < ns; i = i + 1) shift({3'h0, sa[23-i]});
			for (i = 0; i < nn; i = i + 1) shift(nb[63-4*i -: 4]);
			half;
			cs_n_o <= 1'b1;
			io_o <= ~io_o;
			half;
		end
	endtask
endmodule

// ==== verification/fpe_sequencer_test.sv ====
// self-checking bench of the program/erase/power-down sequencer
`timescale 1ns/10ps
module fpe_sequencer_test;
	reg          clk_i;
	reg          rst_i;
	reg  [4:0]   lock_r;
	reg          cmp_r;
	wire         cs_n, sclk, wl, busy, slp, pwe, ers;
	wire [3:0]   io;
	wire [23:0]  paddr, eaddr;
	wire [7:0]   pdata;
	wire [1:0]   kind;
	logic [32:0] exp_q[$];
	integer      miscompares = 0;
	integer      cmp_count = 0;
	integer      i;
	reg  [7:0]   d0, d1;
	reg  [23:0]  a;
	// 25 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	fpe_host u_fpe_host (.clk_i(clk_i), .cs_n_o(cs_n), .sclk_o(sclk), .io_o(io));
	fpe_sequencer #(.PP_CYC(400), .SE_CYC(300), .BE_CYC(300), .CE_CYC(300), .DP_CYC(20), .RES_CYC(30))
	u_fpe_sequencer (.clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sclk_i(sclk), .io_line0_i(io[0]),
		.io_line1_i(io[1]), .io_line2_i(io[2]), .io_line3_i(io[3]), .region_lock_bit4_i(lock_r[4]),
		.region_lock_bit3_i(lock_r[3]), .region_lock_bit2_i(lock_r[2]), .region_lock_bit1_i(lock_r[1]),
		.region_lock_bit0_i(lock_r[0]), .protect_complement_bit_i(cmp_r), .write_latch_flag_o(wl),
		.op_in_progress_flag_o(busy), .sleep_o(slp), .prog_we_o(pwe), .prog_addr_o(paddr),
		.prog_data_o(pdata), .erase_o(ers), .erase_kind_o(kind), .erase_addr_o(eaddr));
	// address bits that name the erased region
	function [23:0] msk(input [1:0] k);
		msk = (k == 2'h0) ? 24'hfff000 : (k == 2'h1) ? 24'hff8000 : (k == 2'h2) ? 24'hff0000 : 24'h000000;
	endfunction
	// compare of a level or count
	task chk(input [32:0] got, input [32:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (got !== exp) begin
				miscompares = miscompares + 1;
				$display("[ERR] %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	// compare of a strobe against the oldest note
	task chk_note(input [32:0] got);
		chk(got, (exp_q.size() > 0) ? exp_q.pop_front() : 33'hx);
	endtask
	task stop_test;
		begin
			$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
			if (miscompares == 0 && cmp_count > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	// bounded wait for the cycle to end
	task settle;
		integer n;
		begin
			n = 0;
			repeat (8) @(posedge clk_i);
			while (busy !== 1'b0 && n < 3000) begin
				@(posedge clk_i);
				n = n + 1;
			end
			if (busy !== 1'b0) begin
				miscompares = miscompares + 1;
				stop_test;
			end
		end
	endtask
	task set_write_latch_cmd;
		begin
			u_fpe_host.frame(8'h06, 0, 0, 0, 0);
			settle;
		end
	endtask
	// watcher of byte writes and erase strobes
	always @(posedge clk_i) begin
		if (pwe === 1'b1) chk_note({1'b0, paddr, pdata});
		if (ers === 1'b1) chk_note({1'b1, 6'h0, kind, eaddr & msk(kind)});
	end
	// main sequence
	initial begin
		rst_i = 1'b1;
		lock_r = 5'h00;
		cmp_r = 1'b0;
		i = $urandom(4);
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk({wl, busy, slp}, 0);
		a = $urandom & 24'h7fffff;
		u_fpe_host.frame(8'h20, 24, a, 0, 0);
		settle;
		chk({wl, busy}, 0);
		$display("test no latch done");
		set_write_latch_cmd;
		chk(wl, 1);
		d0 = $urandom;
		d1 = $urandom;
		exp_q.push_back({1'b0, a[23:8], 8'h10, d0});
		exp_q.push_back({1'b0, a[23:8], 8'h11, d1});
		u_fpe_host.frame(8'h32, 0, 0, 10, {a[23:8], 8'h10, d0, d1, 24'h0});
		repeat (12) @(posedge clk_i);
		chk(busy, 1);
		settle;
		chk(wl, 0);
		set_write_latch_cmd;
		exp_q.push_back({1'b0, a[23:8], 8'h00, d1});
		exp_q.push_back({1'b0, a[23:8], 8'hff, d0});
		u_fpe_host.frame(8'h32, 0, 0, 10, {a[23:8], 8'hff, d0, d1, 24'h0});
		settle;
		set_write_latch_cmd;
		u_fpe_host.frame(8'h32, 0, 0, 9, {a, d0, 32'h0});
		settle;
		lock_r <= 5'h07;
		set_write_latch_cmd;
		u_fpe_host.frame(8'h32, 0, 0, 8, {24'hfffff0, d1, 32'h0});
		settle;
		lock_r <= 5'h00;
		$display("test page write done");
		for (i = 0; i < 3; i = i + 1) begin
			set_write_latch_cmd;
			exp_q.push_back({1'b1, 6'h0, i[1:0], a & msk(i[1:0])});
			u_fpe_host.frame(i == 0 ? 8'h20 : i == 1 ? 8'h52 : 8'hd8, 24, a, 0, 0);
			settle;
		end
		set_write_latch_cmd;
		u_fpe_host.frame(8'h20, 23, a, 0, 0);
		u_fpe_host.frame(8'h60, 1, a, 0, 0);
		settle;
		lock_r <= 5'h07;
		cmp_r <= 1'b1;
		for (i = 0; i < 2; i = i + 1) begin
			d0 = $urandom;
			lock_r <= {d0[1:0], 3'h7};
			set_write_latch_cmd;
			exp_q.push_back({1'b1, 8'h03, 24'h0});
			u_fpe_host.frame(i == 0 ? 8'h60 : 8'hc7, 0, 0, 0, 0);
			settle;
		end
		cmp_r <= 1'b0;
		set_write_latch_cmd;
		u_fpe_host.frame(8'hc7, 0, 0, 0, 0);
		settle;
		chk(wl, 1);
		lock_r <= 5'h11;
		u_fpe_host.frame(8'h20, 24, a, 0, 0);
		settle;
		chk(wl, 1);
		lock_r <= 5'h09;
		exp_q.push_back({1'b1, 8'h00, a & 24'hfff000});
		u_fpe_host.frame(8'h20, 24, a, 0, 0);
		settle;
		chk(wl, 0);
		lock_r <= 5'h00;
		$display("test erase done");
		set_write_latch_cmd;
		exp_q.push_back({1'b1, 8'h00, a & 24'hfff000});
		u_fpe_host.frame(8'h20, 24, a, 0, 0);
		u_fpe_host.frame(8'hb9, 0, 0, 0, 0);
		settle;
		chk(slp, 0);
		for (i = 0; i < 2; i = i + 1) begin
			u_fpe_host.frame(8'hb9, 0, 0, 0, 0);
			chk(slp, 0);
			repeat (40) @(posedge clk_i);
			chk(slp, 1);
			u_fpe_host.frame(8'h06, 0, 0, 0, 0);
			chk(wl, 0);
			u_fpe_host.frame(i == 0 ? 8'hab : 8'h66, 0, 0, 0, 0);
			if (i == 1) u_fpe_host.frame(8'h99, 0, 0, 0, 0);
			repeat (60) @(posedge clk_i);
			chk(slp, 0);
		end
		set_write_latch_cmd;
		chk(wl, 1);
		$display("test sleep done");
		chk(exp_q.size(), 0);
		stop_test;
	end
endmodule
